/* aer_pkg.sv */
package aer_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_COR_STATUS = 12'h110;
    localparam logic [11:0] OFF_COR_MASK = 12'h114;
    localparam logic [11:0] OFF_CAP_CTRL = 12'h118;
    localparam logic [11:0] OFF_HDR_WORD1 = 12'h11c;
    localparam logic [11:0] OFF_HDR_WORD2 = 12'h120;
    localparam logic [11:0] OFF_HDR_WORD3 = 12'h124;
    localparam logic [11:0] OFF_HDR_WORD4 = 12'h128;
    localparam logic [11:0] OFF_SEC_STATUS = 12'h12c;
    localparam logic [11:0] OFF_SEC_MASK = 12'h130;
    localparam logic [11:0] OFF_SEC_SEVERITY = 12'h134;
    localparam logic [11:0] OFF_SEC_CTRL = 12'h138;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h140;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h144;

    // ------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] COR_IMPL = 32'h0000_11c1;
    localparam logic [31:0] SEC_IMPL = 32'h0000_3fef;
    localparam logic [31:0] SEC_MASK_RST = 32'h0000_17a8;
    localparam logic [31:0] SEC_SEV_RST = 32'h0000_1340;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;
    localparam int PTR_LSB = 0;
    localparam int PTR_W = 5;
    localparam int CRC_GEN_CAP_BIT = 5;
    localparam int CRC_GEN_EN_BIT = 6;
    localparam int CRC_CHK_CAP_BIT = 7;
    localparam int CRC_CHK_EN_BIT = 8;
    localparam int HDR_WORDS = 4;
    localparam int IRQ_W = 4;
    // interrupt status bit positions
    localparam int IRQ_COR = 0;
    localparam int IRQ_SEC_NONFATAL = 1;
    localparam int IRQ_SEC_FATAL = 2;
    localparam int IRQ_HDR_CAPTURED = 3;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;  // byte address
        logic [31:0] wdata;  // write data
        logic wr;  // write strobe
        logic rd;  // read strobe
    } aer_bus_req_t;

    typedef struct packed {
        logic [31:0] cor;  // correctable error pulses
        logic [31:0] sec;  // secondary error pulses
        logic [127:0] header;  // header of offending packet, byte 0 at top
        logic header_valid;  // header goes with these errors
    } aer_events_t;

endpackage : aer_pkg

/* aer_regs.sv */
`timescale 1ns/1ns
module aer_regs
(
    // clock and resets
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sticky_rst_b,
    // register port
    input wire aer_pkg::aer_bus_req_t bus_req,
    output logic [31:0] rd_data,
    // error events from the bridge
    input wire aer_pkg::aer_events_t events,
    // control outputs
    output logic crc_gen_enable,
    output logic crc_chk_enable,
    output logic fatal_err,
    output logic irq
);
    import aer_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // read words and pointer indexing assume these sizes
    if (PTR_W != 5 || HDR_WORDS != 4 || IRQ_W != 4)
    begin : g_bad_sizes
        $error("unsupported size constants");
    end

    // ------------------------------------------------------------
    // reset synchronisers
    // ------------------------------------------------------------
    // hazard: raw reset pins reach no logic before both flops
    logic rst_meta_b;  // first stage, ordinary reset
    logic rst_sync_b;  // released ordinary reset
    logic sty_meta_b;  // first stage, sticky reset
    logic sty_sync_b;  // released sticky reset

    // two-flop release of the ordinary reset
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // two-flop release of the power-on reset that clears sticky state
    always_ff @(posedge clock or negedge sticky_rst_b)
    begin
        if (!sticky_rst_b)
        begin
            sty_meta_b <= 1'b0;
            sty_sync_b <= 1'b0;
        end
        else
        begin
            sty_meta_b <= 1'b1;
            sty_sync_b <= sty_meta_b;
        end
    end

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [31:0] cor_status;  // correctable status
    logic [31:0] cor_mask;  // correctable mask
    logic [PTR_W-1:0] first_ptr;  // first error pointer
    logic crc_gen_en;  // crc generation enable
    logic crc_chk_en;  // crc check enable
    logic [31:0] hdr_word [HDR_WORDS];  // captured header
    logic [31:0] sec_status;  // secondary status
    logic [31:0] sec_mask;  // secondary mask
    logic [31:0] sec_sev;  // secondary severity
    logic [PTR_W-1:0] sec_ptr;  // secondary first error pointer
    logic sec_ptr_held;  // pointer loaded since power-on
    logic [IRQ_W-1:0] irq_status;  // interrupt status, read clears
    logic [IRQ_W-1:0] irq_mask;  // interrupt enables

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // one hit per register on the byte address
    wire hit_cor_st = bus_req.addr == OFF_COR_STATUS;
    wire hit_cor_mk = bus_req.addr == OFF_COR_MASK;
    wire hit_ctrl = bus_req.addr == OFF_CAP_CTRL;
    wire hit_sec_st = bus_req.addr == OFF_SEC_STATUS;
    wire hit_sec_mk = bus_req.addr == OFF_SEC_MASK;
    wire hit_sec_sv = bus_req.addr == OFF_SEC_SEVERITY;
    wire hit_irq_st = bus_req.addr == OFF_IRQ_STATUS;
    wire hit_irq_mk = bus_req.addr == OFF_IRQ_MASK;
    wire hit_hdr_1 = bus_req.addr == OFF_HDR_WORD1;
    wire hit_hdr_2 = bus_req.addr == OFF_HDR_WORD2;
    wire hit_hdr_3 = bus_req.addr == OFF_HDR_WORD3;
    wire hit_hdr_4 = bus_req.addr == OFF_HDR_WORD4;
    wire hit_sec_pt = bus_req.addr == OFF_SEC_CTRL;
    // write strobes; read-only words have none
    wire wr_cor_st = bus_req.wr && hit_cor_st;
    wire wr_cor_mk = bus_req.wr && hit_cor_mk;
    wire wr_ctrl = bus_req.wr && hit_ctrl;
    wire wr_sec_st = bus_req.wr && hit_sec_st;
    wire wr_sec_mk = bus_req.wr && hit_sec_mk;
    wire wr_sec_sv = bus_req.wr && hit_sec_sv;
    wire wr_irq_mk = bus_req.wr && hit_irq_mk;
    // reading the interrupt status clears it
    wire rd_irq_st = bus_req.rd && hit_irq_st;

    // ------------------------------------------------------------
    // error tracking
    // ------------------------------------------------------------
    // only implemented positions can record an event
    wire [31:0] cor_ev = events.cor & COR_IMPL;
    wire [31:0] sec_ev = events.sec & SEC_IMPL;
    // masked errors still record status, they skip the pointer, the interrupt causes and fatal_err
    wire [31:0] sec_unmasked = sec_ev & ~sec_mask;
    // pointed-at status bit, for the "still pending" test
    wire sec_ptr_pending = sec_status[sec_ptr];
    wire sec_any_unmasked = |sec_unmasked;
    // free before the first load, or once the status behind it is cleared;
    // a masked error at the reset index cannot block the pointer
    wire sec_ptr_free = !sec_ptr_held || !sec_ptr_pending;
    // pointer loads here; header loads in the same cycle only when header_valid is set
    wire load_ptr = sec_any_unmasked && sec_ptr_free;

    // lowest-numbered unmasked error wins the pointer
    logic [PTR_W-1:0] sec_first_idx;
    always_comb
    begin
        sec_first_idx = '0;
        for (int i = 31; i >= 0; i--)
        begin
            if (sec_unmasked[i])
            begin
                sec_first_idx = PTR_W'(i);
            end
        end
    end

    // next status values: set wins over write-one clear
    wire [31:0] next_cor_status = (wr_cor_st
        ? (cor_status & ~bus_req.wdata) : cor_status)
        | cor_ev;
    wire [31:0] next_sec_status = (wr_sec_st
        ? (sec_status & ~bus_req.wdata) : sec_status)
        | sec_ev;

    // interrupt causes
    wire cor_unmasked = |(cor_ev & ~cor_mask);
    wire sec_fatal_ev = |(sec_unmasked & sec_sev);
    wire sec_nonfatal_ev = |(sec_unmasked & ~sec_sev);
    logic [IRQ_W-1:0] irq_ev;
    always_comb
    begin
        irq_ev = '0;
        irq_ev[IRQ_COR] = cor_unmasked;
        irq_ev[IRQ_SEC_NONFATAL] = sec_nonfatal_ev;
        irq_ev[IRQ_SEC_FATAL] = sec_fatal_ev;
        irq_ev[IRQ_HDR_CAPTURED] = load_ptr && events.header_valid;
    end
    // a read clear loses to a new event in the same cycle
    wire [IRQ_W-1:0] next_irq_status =
        (rd_irq_st ? '0 : irq_status) | irq_ev;

    // ------------------------------------------------------------
    // sticky registers, kept over ordinary reset
    // ------------------------------------------------------------
    // only the power-on reset clears these, the ordinary one does not
    // correctable status and mask
    always_ff @(posedge clock or negedge sty_sync_b)
    begin
        if (!sty_sync_b)
        begin
            cor_status <= ZERO_RST;
            cor_mask <= ZERO_RST;
        end
        else
        begin
            cor_status <= next_cor_status & COR_IMPL;
            if (wr_cor_mk)
            begin
                cor_mask <= bus_req.wdata & COR_IMPL;
            end
        end
    end

    // crc enables
    always_ff @(posedge clock or negedge sty_sync_b)
    begin
        if (!sty_sync_b)
        begin
            crc_gen_en <= 1'b0;
            crc_chk_en <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            crc_gen_en <= bus_req.wdata[CRC_GEN_EN_BIT];
            crc_chk_en <= bus_req.wdata[CRC_CHK_EN_BIT];
        end
    end

    // secondary status, mask, severity
    always_ff @(posedge clock or negedge sty_sync_b)
    begin
        if (!sty_sync_b)
        begin
            sec_status <= ZERO_RST;
            sec_mask <= SEC_MASK_RST;
            sec_sev <= SEC_SEV_RST;
        end
        else
        begin
            sec_status <= next_sec_status & SEC_IMPL;
            if (wr_sec_mk)
            begin
                sec_mask <= bus_req.wdata & SEC_IMPL;
            end
            if (wr_sec_sv)
            begin
                sec_sev <= bus_req.wdata & SEC_IMPL;
            end
        end
    end

    // pointers: secondary one tracks bridge errors, primary mirrors it
    // primary errors live outside this block, so the mirror is exact
    always_ff @(posedge clock or negedge sty_sync_b)
    begin
        if (!sty_sync_b)
        begin
            sec_ptr <= '0;
            first_ptr <= '0;
            sec_ptr_held <= 1'b0;
        end
        else if (load_ptr)
        begin
            sec_ptr <= sec_first_idx;
            first_ptr <= sec_first_idx;
            sec_ptr_held <= 1'b1;
        end
    end

    // header capture, one word per entry
    genvar gw;
    generate
        for (gw = 0; gw < HDR_WORDS; gw++)
        begin : g_hdr
            always_ff @(posedge clock or negedge sty_sync_b)
            begin
                if (!sty_sync_b)
                begin
                    hdr_word[gw] <= ZERO_RST;
                end
                else if (load_ptr && events.header_valid)
                begin
                    // captured only with a pointer load and header_valid, so a captured header matches the pointer
                    // byte 4*gw lands in bits 31:24
                    hdr_word[gw] <=
                        events.header[127-32*gw -: 32];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupt block, ordinary reset
    // ------------------------------------------------------------
    // status set by events, cleared by a read of it
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            irq_status <= '0;
            irq_mask <= '0;
        end
        else
        begin
            irq_status <= next_irq_status;
            if (wr_irq_mk)
            begin
                irq_mask <= bus_req.wdata[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read path, data one cycle after the strobe
    // ------------------------------------------------------------
    // capability bits are fixed ones, pointer and enable bits from storage, unused bits zero
    logic [31:0] ctrl_word;  // control word image
    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[PTR_LSB +: PTR_W] = first_ptr;
        ctrl_word[CRC_GEN_CAP_BIT] = 1'b1;
        ctrl_word[CRC_GEN_EN_BIT] = crc_gen_en;
        ctrl_word[CRC_CHK_CAP_BIT] = 1'b1;
        ctrl_word[CRC_CHK_EN_BIT] = crc_chk_en;
    end

    // address chain, first hit wins
    logic [31:0] rd_mux;  // selected read word
    always_comb
    begin
        if (hit_cor_st)
            rd_mux = cor_status;
        else if (hit_cor_mk)
            rd_mux = cor_mask;
        else if (hit_ctrl)
            rd_mux = ctrl_word;
        else if (hit_hdr_1)
            rd_mux = hdr_word[0];
        else if (hit_hdr_2)
            rd_mux = hdr_word[1];
        else if (hit_hdr_3)
            rd_mux = hdr_word[2];
        else if (hit_hdr_4)
            rd_mux = hdr_word[3];
        else if (hit_sec_st)
            rd_mux = sec_status;
        else if (hit_sec_mk)
            rd_mux = sec_mask;
        else if (hit_sec_sv)
            rd_mux = sec_sev;
        else if (hit_sec_pt)
            rd_mux = {27'h0, sec_ptr};
        else if (hit_irq_st)
            rd_mux = {28'h0, irq_status};
        else if (hit_irq_mk)
            rd_mux = {28'h0, irq_mask};
        else
            rd_mux = 32'h0;  // unmapped reads zero
    end

    // read data register, zero outside the answer cycle
    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            rd_data <= 32'h0;
        end
        else
        begin
            rd_data <= bus_req.rd ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // enables straight from the sticky bits
    assign crc_gen_enable = crc_gen_en;
    assign crc_chk_enable = crc_chk_en;
    // fatal: pending, unmasked and marked fatal
    assign fatal_err = |(sec_status & ~sec_mask & sec_sev);
    // level interrupt while an enabled cause is pending
    assign irq = |(irq_status & irq_mask);

endmodule : aer_regs

/* aer_regs_checker.sv */
`timescale 1ns/1ns
module aer_regs_checker
(
    // clock and resets
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sticky_rst_b,
    // register port
    input wire aer_pkg::aer_bus_req_t bus_req,
    input wire logic [31:0] rd_data,
    // events and outputs
    input wire aer_pkg::aer_events_t events,
    input wire logic crc_gen_enable,
    input wire logic crc_chk_enable,
    input wire logic fatal_err,
    input wire logic irq
);
    import aer_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b || !sticky_rst_b);
    // read data only in the slot after a read
    property p_rd_idle;
        !$past(bus_req.rd) |-> rd_data == 32'h0;
    endproperty
    // correctable reserved bits read zero
    property p_cor_rsvd;
        $past(bus_req.rd) && ($past(bus_req.addr) == OFF_COR_STATUS ||
        $past(bus_req.addr) == OFF_COR_MASK) |-> (rd_data & ~COR_IMPL) == 0;
    endproperty
    // capability bits one, upper bits zero
    property p_ctrl_caps;
        $past(bus_req.rd) && $past(bus_req.addr) == OFF_CAP_CTRL |->
        rd_data[31:9] == 23'h0 && rd_data[7] && rd_data[5];
    endproperty
    // secondary words keep only implemented bits
    property p_sec_rsvd;
        $past(bus_req.rd) && ($past(bus_req.addr) == OFF_SEC_STATUS ||
        $past(bus_req.addr) == OFF_SEC_MASK ||
        $past(bus_req.addr) == OFF_SEC_SEVERITY) |->
        (rd_data & ~SEC_IMPL) == 0;
    endproperty
    // pointer word upper bits zero
    property p_sec_ptr;
        $past(bus_req.rd) && $past(bus_req.addr) == OFF_SEC_CTRL |->
        rd_data[31:5] == 27'h0;
    endproperty
    // enables follow the control write
    property p_gen_en;
        bus_req.wr && bus_req.addr == OFF_CAP_CTRL |=>
        crc_gen_enable == $past(bus_req.wdata[CRC_GEN_EN_BIT]);
    endproperty
    property p_chk_en;
        bus_req.wr && bus_req.addr == OFF_CAP_CTRL |=>
        crc_chk_enable == $past(bus_req.wdata[CRC_CHK_EN_BIT]);
    endproperty
    // fatal only after a secondary event or a write
    property p_fatal_cause;
        $rose(fatal_err) |-> $past(events.sec != 32'h0 || bus_req.wr);
    endproperty
    // interrupt only after an event or a write
    property p_irq_cause;
        $rose(irq) |->
        $past(events.cor != 32'h0 || events.sec != 32'h0 || bus_req.wr);
    endproperty
    // ------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    a_cor_rsvd: assert property (p_cor_rsvd)
        else $error("correctable reserved bit set");
    a_ctrl_caps: assert property (p_ctrl_caps)
        else $error("capability field wrong");
    a_sec_rsvd: assert property (p_sec_rsvd)
        else $error("secondary reserved bit set");
    a_sec_ptr: assert property (p_sec_ptr)
        else $error("pointer word upper bits set");
    a_gen_en: assert property (p_gen_en)
        else $error("generation enable wrong");
    a_chk_en: assert property (p_chk_en)
        else $error("check enable wrong");
    a_fatal_cause: assert property (p_fatal_cause)
        else $error("fatal rose without cause");
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt rose without cause");
    c_fatal: cover property ($rose(fatal_err));
    c_irq: cover property ($rose(irq));
    c_rd_sec: cover property (bus_req.rd && bus_req.addr == OFF_SEC_STATUS);
endmodule : aer_regs_checker

bind aer_regs aer_regs_checker aer_regs_checker_i (.clock(clock),
    .rst_b(rst_b), .sticky_rst_b(sticky_rst_b), .bus_req(bus_req),
    .rd_data(rd_data), .events(events), .crc_gen_enable(crc_gen_enable),
    .crc_chk_enable(crc_chk_enable), .fatal_err(fatal_err), .irq(irq));

/* advanced_error_report_regs_bench.sv */
`timescale 1ns/1ns
module advanced_error_report_regs_bench;
    import aer_pkg::*;
    // table row: request beside expected read-back
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } aer_row_t;
    localparam logic [127:0] HDR =
        128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
    logic clock;
    logic rst_b;
    logic sticky_rst_b;
    aer_bus_req_t bus_req;
    logic [31:0] rd_data;
    aer_events_t events;
    logic crc_gen_enable;
    logic crc_chk_enable;
    logic fatal_err;
    logic irq;
    int miscompares;
    int compares;
    int cycles;
    logic [31:0] v;
    aer_row_t rows [0:24];

    aer_regs aer_regs_i (.clock(clock), .rst_b(rst_b),
        .sticky_rst_b(sticky_rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .events(events), .crc_gen_enable(crc_gen_enable),
        .crc_chk_enable(crc_chk_enable), .fatal_err(fatal_err), .irq(irq));

    // ------------------------------------------------------------
    // clock, timeout, tasks
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // cut a hang short
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            print_verdict;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req <= '0;
    endtask : wr_reg
    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1 chk(rd_data, exp);
    endtask : rd_chk
    // one cycle of error pulses with a header
    task ev(input logic [31:0] c, input logic [31:0] s,
        input logic [127:0] h);
        @(posedge clock);
        events <= '{cor: c, sec: s, header: h, header_valid: 1'b1};
        @(posedge clock);
        events <= '0;
    endtask : ev
    task print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        sticky_rst_b = 1'b0;
        bus_req = '0;
        events = '0;
        rows = '{'{1'b0, 12'h110, 32'h0, 32'h0},
            '{1'b0, 12'h114, 32'h0, 32'h0},
            '{1'b0, 12'h118, 32'h0, 32'ha0}, '{1'b0, 12'h11c, 32'h0, 32'h0},
            '{1'b0, 12'h120, 32'h0, 32'h0}, '{1'b0, 12'h124, 32'h0, 32'h0},
            '{1'b0, 12'h128, 32'h0, 32'h0}, '{1'b0, 12'h12c, 32'h0, 32'h0},
            '{1'b0, 12'h130, 32'h0, 32'h17a8},
            '{1'b0, 12'h134, 32'h0, 32'h1340},
            '{1'b0, 12'h138, 32'h0, 32'h0}, '{1'b0, 12'h144, 32'h0, 32'h0},
            '{1'b1, 12'h110, '1, 32'h0}, '{1'b1, 12'h114, '1, 32'h11c1},
            '{1'b1, 12'h118, '1, 32'h1e0}, '{1'b1, 12'h11c, '1, 32'h0},
            '{1'b1, 12'h12c, '1, 32'h0}, '{1'b1, 12'h130, '1, 32'h3fef},
            '{1'b1, 12'h134, 32'h0, 32'h0}, '{1'b1, 12'h138, '1, 32'h0},
            '{1'b1, 12'h14c, '1, 32'h0}, '{1'b1, 12'h114, 32'h0, 32'h0},
            '{1'b1, 12'h130, 32'h0, 32'h0},
            '{1'b1, 12'h134, 32'h1340, 32'h1340},
            '{1'b1, 12'h144, 32'hf, 32'hf}};
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        sticky_rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        // reset values and access kinds
        foreach (rows[i])
        begin
            if (rows[i].wr)
                wr_reg(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].exp);
        end
        // the all-ones control write left both enables on
        chk({31'h0, crc_gen_enable}, 32'h1);
        chk({31'h0, crc_chk_enable}, 32'h1);
        // first unmasked secondary errors load pointer and header
        ev(32'h0, 32'h220, HDR);
        #1 chk({31'h0, fatal_err}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rd_chk(OFF_SEC_STATUS, 32'h220);
        rd_chk(OFF_SEC_CTRL, 32'h5);
        rd_chk(OFF_CAP_CTRL, 32'h1e5);
        for (int i = 0; i < HDR_WORDS; i++)
            rd_chk(OFF_HDR_WORD1 + 12'(4 * i),
                HDR[127 - 32 * i -: 32]);
        rd_chk(OFF_IRQ_STATUS, 32'he);
        rd_chk(OFF_IRQ_STATUS, 32'h0);
        // a later error leaves pointer and header alone
        ev(32'h0, 32'h1, ~HDR);
        rd_chk(OFF_SEC_CTRL, 32'h5);
        rd_chk(OFF_HDR_WORD1, 32'h0011_2233);
        // ordinary reset keeps sticky state
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        chk({31'h0, crc_gen_enable}, 32'h1);
        rd_chk(OFF_SEC_STATUS, 32'h221);
        wr_reg(OFF_SEC_STATUS, 32'h20);
        rd_chk(OFF_SEC_STATUS, 32'h201);
        wr_reg(OFF_SEC_STATUS, 32'h201);
        rd_chk(OFF_SEC_STATUS, 32'h0);
        chk({31'h0, fatal_err}, 32'h0);
        // pointed-at status cleared: the next error reloads both
        ev(32'h0, 32'h2000, ~HDR);
        rd_chk(OFF_SEC_CTRL, 32'hd);
        rd_chk(OFF_HDR_WORD1, 32'hffee_ddcc);
        rd_chk(OFF_IRQ_STATUS, 32'ha);
        // correctable errors, interrupt masked then unmasked
        wr_reg(OFF_IRQ_MASK, 32'h0);
        ev('1, 32'h0, HDR);
        #1 chk({31'h0, irq}, 32'h0);
        rd_chk(OFF_COR_STATUS, 32'h11c1);
        wr_reg(OFF_IRQ_MASK, 32'h1);
        #1 chk({31'h0, irq}, 32'h1);
        rd_chk(OFF_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr_reg(OFF_COR_STATUS, 32'h1);
        rd_chk(OFF_COR_STATUS, 32'h11c0);
        // a new event beats a clear in the same cycle
        @(posedge clock);
        bus_req <= '{addr: OFF_COR_STATUS, wdata: 32'h1, wr: 1'b1, rd: 1'b0};
        events <= '{cor: 32'h1, sec: 32'h0, header: HDR, header_valid: 1'b0};
        @(posedge clock);
        bus_req <= '0;
        events <= '0;
        rd_chk(OFF_COR_STATUS, 32'h11c1);
        rd_chk(OFF_IRQ_STATUS, 32'h1);
        // a masked correctable error records status but raises no cause
        wr_reg(OFF_COR_MASK, 32'h40);
        wr_reg(OFF_COR_STATUS, '1);
        ev(32'h40, 32'h0, HDR);
        rd_chk(OFF_COR_STATUS, 32'h40);
        rd_chk(OFF_IRQ_STATUS, 32'h0);
        // enables follow their own bits only
        wr_reg(OFF_CAP_CTRL, 32'h40);
        #1 chk({31'h0, crc_gen_enable}, 32'h1);
        chk({31'h0, crc_chk_enable}, 32'h0);
        rd_chk(OFF_CAP_CTRL, 32'hed);
        print_verdict;
    end
endmodule : advanced_error_report_regs_bench
